// [ddr3_bank_cmd.sv]
// Bank state, command spacing checks and read burst output sequencing
`timescale 1ns/10ps
`default_nettype none
module ddr3_bank_cmd
  import ddr3_cmd_pkg::*;
#(
  parameter int FIFO_WORDS = ddr3_cmd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Decoded command from the pins
  input wire ddr3_cmd_pkg::cmd_t cmd_in,
  input wire logic [ddr3_cmd_pkg::BA_W-1:0] bank_in,
  input wire logic [ddr3_cmd_pkg::ROW_W-1:0] addr_in,
  // Mode settings
  input wire logic [ddr3_cmd_pkg::LAT_W-1:0] cas_lat_in,
  input wire logic [ddr3_cmd_pkg::LAT_W-1:0] add_lat_in,
  input wire logic [ddr3_cmd_pkg::LAT_W-1:0] write_lat_in,
  input wire logic [1:0] burst_mode_in,
  // Array read data, one element per beat
  input wire logic [ddr3_cmd_pkg::DQ_W-1:0] array_data_in,
  // Array access request
  output logic array_rd_out,
  output logic [ddr3_cmd_pkg::BA_W-1:0] array_bank_out,
  output logic [ddr3_cmd_pkg::ROW_W-1:0] array_row_out,
  output logic [ddr3_cmd_pkg::COL_W-1:0] array_col_out,
  // Data and strobe pins
  output logic [ddr3_cmd_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic dqs_out,
  output logic dqs_n_out,
  output logic dqs_oe_out,
  // Status
  output logic [ddr3_cmd_pkg::BANKS-1:0] bank_open_out,
  output logic all_idle_out,
  output logic cmd_reject_out,
  output ddr3_cmd_pkg::err_t reject_code_out
);
  import ddr3_cmd_pkg::*;

  // ********************************
  // Bank state and timers
  // ********************************
  logic [BANKS-1:0] open_r;
  logic [ROW_W-1:0] row_r [BANKS];
  logic [TIMER_W-1:0] rcd_r [BANKS];
  logic [TIMER_W-1:0] rc_r [BANKS];
  logic [TIMER_W-1:0] ras_r [BANKS];
  logic [TIMER_W-1:0] rp_r [BANKS];
  logic [TIMER_W-1:0] rtp_r [BANKS];
  logic [BANKS-1:0] ap_pend_r;
  logic [TIMER_W-1:0] ap_cnt_r [BANKS];
  logic [TIMER_W-1:0] rrd_r;
  logic [TIMER_W-1:0] ccd_r;
  logic [TIMER_W-1:0] rtw_r;
  logic [TIMER_W-1:0] faw_r [FAW_ACTS];
  logic [1:0] faw_idx_r;
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic pre_all;
  logic auto_pre;
  logic bc4;
  err_t err;
  logic ok;

  assign is_act = (cmd_in == CMD_ACT);
  assign is_pre = (cmd_in == CMD_PRE);
  assign is_rd = (cmd_in == CMD_RD);
  assign is_wr = (cmd_in == CMD_WR);
  assign pre_all = addr_in[10];
  assign auto_pre = addr_in[10];
  assign bc4 = (burst_mode_in == BL_FIXED4) || ((burst_mode_in == BL_OTF) && !addr_in[12]);

  // Command check against bank state and spacing counters
  always_comb
  begin
    err = ERR_NONE;
    if (is_act)
    begin
      if (open_r[bank_in] || ap_pend_r[bank_in]) err = ERR_OPEN_BANK;
      else if (rc_r[bank_in] != '0) err = ERR_TRC;
      else if (rp_r[bank_in] != '0) err = ERR_TRP;
      else if (rrd_r != '0) err = ERR_TRRD;
      else if (faw_r[faw_idx_r] != '0) err = ERR_TFAW;
    end
    else if (is_rd || is_wr)
    begin
      if (!open_r[bank_in] || ap_pend_r[bank_in]) err = ERR_IDLE_BANK;
      else if (rcd_r[bank_in] > TIMER_W'(add_lat_in)) err = ERR_TRCD;
      else if (ccd_r != '0) err = ERR_TCCD;
      else if (is_wr && rtw_r != '0) err = ERR_RD_TO_WR;
    end
    else if (is_pre)
    begin
      for (int b = 0; b < BANKS; b++)
      begin
        if ((pre_all || BA_W'(b) == bank_in) && open_r[b])
        begin
          if (ras_r[b] != '0) err = ERR_TRAS;
          else if (rtp_r[b] != '0) err = ERR_TRTP;
        end
      end
    end
  end
  assign ok = (err == ERR_NONE);

  // Per-bank state and timers
  generate
    for (genvar g = 0; g < BANKS; g++)
    begin : g_bank
      logic hit;
      assign hit = (bank_in == BA_W'(g));
      always_ff @(posedge core_clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          open_r[g] <= 1'b0;
          row_r[g] <= '0;
          rcd_r[g] <= '0;
          rc_r[g] <= '0;
          ras_r[g] <= '0;
          rp_r[g] <= '0;
          rtp_r[g] <= '0;
          ap_pend_r[g] <= 1'b0;
          ap_cnt_r[g] <= '0;
        end
        else
        begin
          if (rcd_r[g] != '0) rcd_r[g] <= rcd_r[g] - 1'b1;
          if (rc_r[g] != '0) rc_r[g] <= rc_r[g] - 1'b1;
          if (ras_r[g] != '0) ras_r[g] <= ras_r[g] - 1'b1;
          if (rp_r[g] != '0) rp_r[g] <= rp_r[g] - 1'b1;
          if (rtp_r[g] != '0) rtp_r[g] <= rtp_r[g] - 1'b1;
          if (ap_pend_r[g])
          begin
            if (ap_cnt_r[g] <= 1 && ras_r[g] <= 1)
            begin
              ap_pend_r[g] <= 1'b0;
              open_r[g] <= 1'b0;
              rp_r[g] <= TIMER_W'(TRP_CYC);
            end
            else if (ap_cnt_r[g] != '0)
            begin
              ap_cnt_r[g] <= ap_cnt_r[g] - 1'b1;
            end
          end
          if (ok && is_act && hit)
          begin
            open_r[g] <= 1'b1;
            row_r[g] <= addr_in;
            rcd_r[g] <= TIMER_W'(TRCD_CYC - 1);
            rc_r[g] <= TIMER_W'(TRC_CYC - 1);
            ras_r[g] <= TIMER_W'(TRAS_CYC - 1);
          end
          if (ok && is_pre && (pre_all || hit) && open_r[g])
          begin
            open_r[g] <= 1'b0;
            rp_r[g] <= TIMER_W'(TRP_CYC - 1);
          end
          if (ok && is_rd && hit)
          begin
            rtp_r[g] <= TIMER_W'(add_lat_in) + TIMER_W'(TRTP_CYC - 1);
            if (auto_pre)
            begin
              ap_pend_r[g] <= 1'b1;
              ap_cnt_r[g] <= TIMER_W'(add_lat_in) + TIMER_W'(TRTP_CYC);
            end
          end
        end
      end
    end
  endgenerate

  // Shared spacing counters
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rrd_r <= '0;
      ccd_r <= '0;
      rtw_r <= '0;
      faw_idx_r <= '0;
      for (int i = 0; i < FAW_ACTS; i++) faw_r[i] <= '0;
    end
    else
    begin
      if (rrd_r != '0) rrd_r <= rrd_r - 1'b1;
      if (ccd_r != '0) ccd_r <= ccd_r - 1'b1;
      if (rtw_r != '0) rtw_r <= rtw_r - 1'b1;
      for (int i = 0; i < FAW_ACTS; i++)
      begin
        if (faw_r[i] != '0) faw_r[i] <= faw_r[i] - 1'b1;
      end
      if (ok && is_act)
      begin
        rrd_r <= TIMER_W'(TRRD_CYC - 1);
        faw_r[faw_idx_r] <= TIMER_W'(TFAW_CYC - 1);
        faw_idx_r <= faw_idx_r + 1'b1;
      end
      if (ok && (is_rd || is_wr))
      begin
        ccd_r <= TIMER_W'(TCCD_CYC - 1);
      end
      if (ok && is_rd)
      begin
        rtw_r <= TIMER_W'(cas_lat_in) + TIMER_W'(add_lat_in) + TIMER_W'(TCCD_CYC + 1)
          - TIMER_W'(write_lat_in);
      end
    end
  end

  // ********************************
  // Read latency pipeline and burst sequencer
  // ********************************
  localparam int SLOTS = 4;
  logic [SLOTS-1:0] slot_v_r;
  logic [TIMER_W-1:0] slot_cnt_r [SLOTS];
  logic [COL_W-1:0] slot_col_r [SLOTS];
  logic [BA_W-1:0] slot_bank_r [SLOTS];
  logic [SLOTS-1:0] slot_bc4_r;
  logic [1:0] slot_wr_r;
  logic [1:0] slot_rd_r;
  logic fifo_ready;
  logic [3:0] beats_r;
  logic [2:0] beat_idx_r;
  logic [COL_W-1:0] col_r;
  logic [BA_W-1:0] bank_r;
  logic emit;

  // Reads queue while a burst is still fetched; more than four in flight overwrite
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      slot_v_r <= '0;
      slot_bc4_r <= '0;
      slot_wr_r <= '0;
      slot_rd_r <= '0;
      for (int i = 0; i < SLOTS; i++)
      begin
        slot_cnt_r[i] <= '0;
        slot_col_r[i] <= '0;
        slot_bank_r[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        if (slot_v_r[i] && slot_cnt_r[i] != '0) slot_cnt_r[i] <= slot_cnt_r[i] - 1'b1;
      end
      if (emit)
      begin
        slot_v_r[slot_rd_r] <= 1'b0;
        slot_rd_r <= slot_rd_r + 1'b1;
      end
      if (ok && is_rd)
      begin
        slot_v_r[slot_wr_r] <= 1'b1;
        slot_cnt_r[slot_wr_r] <= TIMER_W'(cas_lat_in) + TIMER_W'(add_lat_in) - TIMER_W'(2);
        slot_col_r[slot_wr_r] <= {addr_in[COL_W-1:3], addr_in[2], 2'b00};
        slot_bank_r[slot_wr_r] <= bank_in;
        slot_bc4_r[slot_wr_r] <= bc4;
        slot_wr_r <= slot_wr_r + 1'b1;
      end
    end
  end

  // Next burst starts as the last element of the current one is fetched
  assign emit = slot_v_r[slot_rd_r] && (slot_cnt_r[slot_rd_r] == '0)
    && ((beats_r == '0) || ((beats_r == 4'h1) && fifo_ready));
  logic fifo_valid;
  logic [DQ_W:0] fifo_data;
  logic drain;

  // Array fetch, one element per cycle; burst cannot be cut short
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      beats_r <= '0;
      beat_idx_r <= '0;
      col_r <= '0;
      bank_r <= '0;
    end
    else if (emit)
    begin
      beats_r <= slot_bc4_r[slot_rd_r] ? 4'(BC4_BEATS) : 4'(BL8_BEATS);
      beat_idx_r <= '0;
      col_r <= slot_col_r[slot_rd_r];
      bank_r <= slot_bank_r[slot_rd_r];
    end
    else if (beats_r != '0 && fifo_ready)
    begin
      beats_r <= beats_r - 1'b1;
      beat_idx_r <= beat_idx_r + 1'b1;
    end
  end

  assign array_rd_out = (beats_r != '0) && fifo_ready;
  assign array_bank_out = bank_r;
  assign array_row_out = row_r[bank_r];
  assign array_col_out = {col_r[COL_W-1:3], col_r[2:0] + beat_idx_r};

  read_fifo #(
    .WIDTH(DQ_W + 1),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .in_valid_in(array_rd_out),
    .in_ready_out(fifo_ready),
    .in_data_in({beats_r == 4'h1, array_data_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(drain),
    .out_data_out(fifo_data)
  );

  // ********************************
  // Strobe and data pins
  // ********************************
  logic pre_r;
  logic drv_r;
  // A following burst already buffered continues without a new preamble
  assign drain = fifo_valid && (drv_r || pre_r || dq_oe_out);

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pre_r <= 1'b0;
      drv_r <= 1'b0;
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      dqs_out <= 1'b0;
      dqs_n_out <= 1'b1;
      dqs_oe_out <= 1'b0;
    end
    else if (fifo_valid && !drv_r && !pre_r && !dq_oe_out)
    begin
      pre_r <= 1'b1;
      dqs_oe_out <= 1'b1;
      dqs_out <= 1'b0;
      dqs_n_out <= 1'b1;
    end
    else if (drain)
    begin
      pre_r <= 1'b0;
      drv_r <= !fifo_data[DQ_W];
      dq_out <= fifo_data[DQ_W-1:0];
      dq_oe_out <= 1'b1;
      // postamble: strobe low on the last element
      dqs_out <= !fifo_data[DQ_W];
      dqs_n_out <= fifo_data[DQ_W];
    end
    else
    begin
      drv_r <= 1'b0;
      pre_r <= 1'b0;
      dq_oe_out <= 1'b0;
      dqs_oe_out <= 1'b0;
      dqs_out <= 1'b0;
      dqs_n_out <= 1'b1;
    end
  end

  // ********************************
  // Status
  // ********************************
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cmd_reject_out <= 1'b0;
      reject_code_out <= ERR_NONE;
    end
    else
    begin
      cmd_reject_out <= !ok;
      reject_code_out <= err;
    end
  end

  assign bank_open_out = open_r;
  assign all_idle_out = (open_r == '0);
endmodule
`default_nettype wire

// [ddr3_bank_cmd_props.sv]
// Port assertions for the bank command timing block
`timescale 1ns/10ps
`default_nettype none
module ddr3_bank_cmd_chk
  import ddr3_cmd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Command
  input wire ddr3_cmd_pkg::cmd_t cmd_in,
  input wire logic [ddr3_cmd_pkg::BA_W-1:0] bank_in,
  input wire logic [ddr3_cmd_pkg::ROW_W-1:0] addr_in,
  // Pins and status
  input wire logic dq_oe_out,
  input wire logic dqs_out,
  input wire logic dqs_n_out,
  input wire logic dqs_oe_out,
  input wire logic [ddr3_cmd_pkg::BANKS-1:0] bank_open_out,
  input wire logic all_idle_out,
  input wire logic cmd_reject_out,
  input wire ddr3_cmd_pkg::err_t reject_code_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  // ****
  // Read strobe framing
  // ****
  sequence s_pre;
    dqs_oe_out && !dq_oe_out && !dqs_out && dqs_n_out;
  endsequence
  sequence s_beat;
    dq_oe_out && dqs_oe_out;
  endsequence
  property p_preamble;
    $rose(dqs_oe_out) |-> s_pre ##1 s_beat;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("strobe preamble missing");
  property p_strobe_pair;
    dqs_oe_out |-> dqs_n_out == !dqs_out;
  endproperty
  a_strobe_pair: assert property (p_strobe_pair)
    else $error("strobe pair not complementary");
  property p_dq_window;
    dq_oe_out |-> dqs_oe_out;
  endproperty
  a_dq_window: assert property (p_dq_window)
    else $error("data driven outside strobe window");
  property p_postamble;
    $fell(dq_oe_out) |-> !$past(dqs_out);
  endproperty
  a_postamble: assert property (p_postamble)
    else $error("last beat without postamble");

  // ****
  // Command checking
  // ****
  property p_code;
    cmd_reject_out == (reject_code_out != ERR_NONE);
  endproperty
  a_code: assert property (p_code)
    else $error("reject flag and code disagree");
  property p_idle_rd;
    cmd_in == CMD_RD && !bank_open_out[bank_in]
      |=> cmd_reject_out && reject_code_out == ERR_IDLE_BANK;
  endproperty
  a_idle_rd: assert property (p_idle_rd)
    else $error("read to idle bank accepted");
  property p_act;
    cmd_in == CMD_ACT && !bank_open_out[bank_in]
      |=> cmd_reject_out || bank_open_out[$past(bank_in)];
  endproperty
  a_act: assert property (p_act)
    else $error("accepted activate left bank closed");
  property p_pre_all;
    cmd_in == CMD_PRE && addr_in[10] |=> cmd_reject_out || all_idle_out;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");
  property p_tccd;
    cmd_in == CMD_RD ##1 (cmd_in == CMD_RD && !cmd_reject_out) |=> cmd_reject_out;
  endproperty
  a_tccd: assert property (p_tccd)
    else $error("reads one cycle apart accepted");
  property p_idle_flag;
    all_idle_out == (bank_open_out == '0);
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("idle flag disagrees with bank state");
endmodule
bind ddr3_bank_cmd ddr3_bank_cmd_chk chk_u (
  .core_clk_in(core_clk_in),
  .reset_in(reset_in),
  .cmd_in(cmd_in),
  .bank_in(bank_in),
  .addr_in(addr_in),
  .dq_oe_out(dq_oe_out),
  .dqs_out(dqs_out),
  .dqs_n_out(dqs_n_out),
  .dqs_oe_out(dqs_oe_out),
  .bank_open_out(bank_open_out),
  .all_idle_out(all_idle_out),
  .cmd_reject_out(cmd_reject_out),
  .reject_code_out(reject_code_out)
);
`default_nettype wire

// [ddr3_bank_cmd_tb_top.sv]
// Self-checking bench for the bank command timing block
`timescale 1ns/10ps
`default_nettype none
module ddr3_bank_cmd_tb_top;
  import ddr3_cmd_pkg::*;
  logic clk;
  logic rst;
  cmd_t cmd;
  logic [2:0] bank;
  logic [13:0] addr;
  logic [4:0] cl = CL_RST;
  logic [4:0] al = AL_RST;
  logic [4:0] wl = 5'h05;
  logic [1:0] mode = BL_FIXED8;
  logic [7:0] arr_d;
  logic [2:0] a_bank;
  logic [13:0] a_row;
  logic [9:0] a_col;
  logic [7:0] dq;
  logic dq_oe, dqs, dqs_n, dqs_oe, all_idle, rej;
  logic [7:0] open_b;
  err_t code;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] beats[$];

  ddr3_ctrl_model m (.core_clk_in(clk), .cmd_out(cmd), .bank_out(bank), .addr_out(addr));
  ddr3_bank_cmd dut_u (.core_clk_in(clk), .reset_in(rst), .cmd_in(cmd), .bank_in(bank),
    .addr_in(addr), .cas_lat_in(cl), .add_lat_in(al), .write_lat_in(wl),
    .burst_mode_in(mode), .array_data_in(arr_d), .array_rd_out(),
    .array_bank_out(a_bank), .array_row_out(a_row), .array_col_out(a_col),
    .dq_out(dq), .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_n_out(dqs_n),
    .dqs_oe_out(dqs_oe), .bank_open_out(open_b), .all_idle_out(all_idle),
    .cmd_reject_out(rej), .reject_code_out(code));

  function automatic logic [7:0] data(logic [2:0] b, logic [13:0] r, logic [9:0] c);
    return r[7:0] ^ {c[4:0], b};
  endfunction
  assign arr_d = data(a_bank, a_row, a_col);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (dq_oe === 1'b1)
      beats.push_back(dq);
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end

  // ****
  // Checking helpers
  // ****
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rj(err_t e);
    chk("reject", {rej, code}, {1'b1, e});
  endtask
  task automatic burst(int n, logic [2:0] b, logic [13:0] r, logic [9:0] c);
    int w;
    w = 0;
    while (beats.size() < n && w < 80)
    begin
      @(negedge clk);
      w++;
    end
    repeat (6) @(negedge clk);
    chk("beats", beats.size(), n);
    for (int i = 0; i < n && i < beats.size(); i++)
      chk("beat", beats[i], data(b, r, {c[9:3], 3'({c[2], 2'b00} + i)}));
    beats.delete();
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk("open", open_b, 16'h0000);
    chk("idle", all_idle, 16'h0001);
    chk("pins", {dqs_n, dqs_oe, dq_oe}, 16'h0004);
  endtask
  task automatic t_idle();
    m.issue(CMD_RD, 3'h2, 14'h0000);
    rj(ERR_IDLE_BANK);
    m.issue(CMD_WR, 3'h5, 14'h0000);
    rj(ERR_IDLE_BANK);
    m.idle(2);
  endtask
  task automatic t_act();
    m.issue(CMD_ACT, 3'h0, 14'h0123);
    chk("act0", {rej, open_b}, 16'h0001);
    m.issue(CMD_ACT, 3'h0, 14'h0456);
    rj(ERR_OPEN_BANK);
    m.issue(CMD_ACT, 3'h1, 14'h0456);
    chk("act1", {rej, open_b}, 16'h0003);
    m.idle(4);
  endtask
  task automatic t_read();
    m.issue(CMD_RD, 3'h0, 14'h0000);
    m.idle(1);
    burst(8, 3'h0, 14'h0123, 10'h000);
    mode = BL_FIXED4;
    m.issue(CMD_RD, 3'h1, 14'h0004);
    m.idle(1);
    burst(4, 3'h1, 14'h0456, 10'h004);
    mode = BL_OTF;
    m.issue(CMD_RD, 3'h1, 14'h1004);
    m.idle(1);
    burst(8, 3'h1, 14'h0456, 10'h004);
    m.issue(CMD_RD, 3'h1, 14'h0000);
    m.idle(1);
    burst(4, 3'h1, 14'h0456, 10'h000);
    mode = BL_FIXED8;
  endtask
  task automatic t_tccd();
    m.issue(CMD_RD, 3'h0, 14'h0000);
    m.issue(CMD_RD, 3'h0, 14'h0000);
    rj(ERR_TCCD);
    m.idle(1);
    burst(8, 3'h0, 14'h0123, 10'h000);
    m.issue(CMD_RD, 3'h0, 14'h0000);
    m.idle(3);
    m.issue(CMD_RD, 3'h0, 14'h0000);
    m.idle(1);
    burst(16, 3'h0, 14'h0123, 10'h000);
  endtask
  task automatic t_rd_wr();
    m.issue(CMD_RD, 3'h0, 14'h0000);
    m.issue(CMD_PRE, 3'h0, 14'h0000);
    rj(ERR_TRTP);
    m.idle(2);
    m.issue(CMD_WR, 3'h0, 14'h0000);
    rj(ERR_RD_TO_WR);
    m.idle(1);
    burst(8, 3'h0, 14'h0123, 10'h000);
    m.issue(CMD_WR, 3'h0, 14'h0000);
    chk("wr_ok", rej, 16'h0000);
    m.idle(4);
  endtask
  task automatic t_lat();
    int w;
    cl = 5'h05;
    al = 5'h02;
    m.issue(CMD_ACT, 3'h4, 14'h0033);
    m.issue(CMD_RD, 3'h4, 14'h0000);
    chk("rd_al", rej, 16'h0000);
    w = 0;
    while (dq_oe !== 1'b1 && w < 40)
    begin
      m.idle(1);
      w++;
    end
    chk("rl", 16'(w), 16'(CL_RST - 5'h03 + AL_RST + 5'h04));
    burst(8, 3'h4, 14'h0033, 10'h000);
    cl = CL_RST;
    al = AL_RST;
  endtask
  task automatic t_pre();
    m.issue(CMD_ACT, 3'h2, 14'h0077);
    m.issue(CMD_PRE, 3'h2, 14'h0000);
    rj(ERR_TRAS);
    m.idle(3);
    m.issue(CMD_PRE, 3'h2, 14'h0000);
    chk("pre_one", {rej, open_b}, 16'h0003);
    m.issue(CMD_RD, 3'h2, 14'h0000);
    rj(ERR_IDLE_BANK);
    m.issue(CMD_PRE, 3'h6, 14'h0400);
    chk("pre_all", {rej, all_idle, open_b}, 16'h0100);
    m.idle(2);
  endtask
  task automatic t_auto();
    m.issue(CMD_ACT, 3'h3, 14'h00a5);
    m.issue(CMD_RD, 3'h3, 14'h0400);
    chk("ap_open", {rej, open_b}, 16'h0008);
    m.idle(1);
    burst(8, 3'h3, 14'h00a5, 10'h000);
    m.idle(10);
    chk("ap_closed", open_b, 16'h0000);
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_idle();
    t_act();
    t_read();
    t_tccd();
    t_rd_wr();
    t_pre();
    t_auto();
    t_lat();
    summarize();
  end
endmodule
`default_nettype wire

// [ddr3_cmd_pkg.sv]
// Constants and types shared by the bank command timing block
package ddr3_cmd_pkg;

  // ********************************
  // Geometry
  // ********************************
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int DQ_W = 8;
  localparam int LAT_W = 5;

  // ********************************
  // Timing, in ns as printed, with cycle counts at 25 ns
  // ********************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TRCD_NS = 15;
  localparam int TRC_NS = 50;
  localparam int TRRD_NS = 10;
  localparam int TFAW_NS = 40;
  localparam int TRP_NS = 15;
  localparam int TRAS_NS = 35;
  localparam int TRCD_CYC = (TRCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRC_CYC = (TRC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRRD_CYC = (TRRD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TFAW_CYC = (TFAW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRP_CYC = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRAS_CYC = (TRAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TCCD_CYC = 4;
  localparam int TRTP_CYC = 5;
  localparam int TIMER_W = 8;
  localparam int FAW_ACTS = 4;

  // ********************************
  // Reset values and burst modes
  // ********************************
  localparam logic [LAT_W-1:0] CL_RST = 5'h08;
  localparam logic [LAT_W-1:0] AL_RST = 5'h00;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int BL8_BEATS = 8;
  localparam int BC4_BEATS = 4;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_PRE = 4'h2,
    CMD_RD = 4'h3,
    CMD_WR = 4'h4,
    CMD_OTHER = 4'h5
  } cmd_t;

  // Violation codes reported on a rejected command
  typedef enum logic [3:0] {
    ERR_NONE = 4'h0,
    ERR_IDLE_BANK = 4'h1,
    ERR_TRCD = 4'h2,
    ERR_TRC = 4'h3,
    ERR_TRRD = 4'h4,
    ERR_TFAW = 4'h5,
    ERR_TCCD = 4'h6,
    ERR_TRAS = 4'h7,
    ERR_TRP = 4'h8,
    ERR_TRTP = 4'h9,
    ERR_OPEN_BANK = 4'ha,
    ERR_RD_TO_WR = 4'hb
  } err_t;

endpackage

// [ddr3_ctrl_model.sv]
// Command source standing in for the memory controller
`timescale 1ns/10ps
`default_nettype none
module ddr3_ctrl_model
  import ddr3_cmd_pkg::*;
(
  // Clock
  input wire logic core_clk_in,
  // Command pins
  output var ddr3_cmd_pkg::cmd_t cmd_out,
  output var logic [ddr3_cmd_pkg::BA_W-1:0] bank_out,
  output var logic [ddr3_cmd_pkg::ROW_W-1:0] addr_out
);
  initial cmd_out = CMD_NOP;
  initial bank_out = '0;
  initial addr_out = '0;
  // Drive one command for one cycle, called at a falling edge
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [13:0] a);
    cmd_out = c;
    bank_out = b;
    addr_out = a;
    @(negedge core_clk_in);
  endtask
  // Released address lines show inverted values; a second call in a row shows the stale ones again
  task automatic idle(input int n);
    cmd_out = CMD_NOP;
    bank_out = ~bank_out;
    addr_out = ~addr_out;
    repeat (n) @(negedge core_clk_in);
  endtask
endmodule
`default_nettype wire

// [read_fifo.sv]
// Read data FIFO between the array and the strobe serialiser
`timescale 1ns/10ps
`default_nettype none
module read_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk_in)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
